// [rtl/slc_core.sv]
// Serial link coder: transmitter and receiver with 4B/5B, 5B/6B and NRZI
//
// Notes on behaviour
// - Strobed word is latched, encoded, then shifted out one bit per clock.
// - Eight-bit mode encodes each nibble into its own five-bit symbol.
// - The encoded byte leaves the device as an NRZI stream.
// - Twelve lines split as 8+4, 9+3 or 10+2 data plus command.
// - Host strobes each word; transmitter acknowledges every accepted word.
// - Strobe while input latch is busy waits for the next byte window.
// - Byte windows with no strobed word carry the Sync symbol.
// - Sync is unique and sets the receiver's byte framing.
// - Received Sync never changes the receiver's output word.
// - Receiver decodes symbols and strobes each decoded word out.
// - Commands and data share the stream, flagged apart at the receiver.
// - Claim flag rises with cascade enable high on first half of non-Sync byte.
// - Claim flag falls when cascade enable falls.
// - Claim flag falls on first half of a Sync byte.
// - Any nonzero command bit sends a command symbol, ignoring data.
// - Nine-bit mode upper half uses 5B/6B; ten-bit mode both halves.
// - NRZI: one bit toggles the line, zero bit holds it.
// - Most significant bit of the upper symbol is sent first.
`timescale 1ns/1ps
`default_nettype none
module slc_core
  import slc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire slc_width_t width_i,
  input  wire slc_word_t  tx_word_i,
  input  wire logic       word_strobe_in_i,
  output logic            tx_ack_o,
  output logic            serial_line_out_o,
  input  wire logic       serial_line_in_i,
  input  wire logic       cascade_enable_in_i,
  output slc_word_t       rx_word_o,
  output logic            rx_data_strobe_o,
  output logic            rx_cmd_strobe_o,
  output logic            rx_violation_o,
  output logic            byte_claimed_flag_o,
  output logic            rx_framed_o
);

  // Mode-dependent byte length
  logic [SLC_CNT_W-1:0] byte_len;
  logic [11:0]          sync_sym;
  always_comb begin
    case (width_i)
      SLC_W9: begin
        byte_len = SLC_CNT_W'(SLC_LEN_W9);
        sync_sym = SLC_SYNC_W9;
      end
      SLC_W10: begin
        byte_len = SLC_CNT_W'(SLC_LEN_W10);
        sync_sym = SLC_SYNC_W10;
      end
      default: begin
        byte_len = SLC_CNT_W'(SLC_LEN_W8);
        sync_sym = SLC_SYNC_W8;
      end
    endcase
  end

  // ---------------- Transmitter ----------------
  logic                 in_full;
  slc_word_t            in_word;
  logic [SLC_CNT_W-1:0] tx_cnt;
  logic [11:0]          tx_shift;
  logic                 tx_bound;
  logic                 cmd_nz;
  logic [11:0]          enc_sym;

  assign tx_bound = (tx_cnt == byte_len - SLC_CNT_W'(1));
  // Ack only when the latch can take the word; host holds strobe until then
  assign tx_ack_o = word_strobe_in_i & ~in_full & ce_i;

  // Input latch: filled on ack, emptied at the byte window
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_full <= 1'b0;
      in_word <= '0;
    end else if (ce_i) begin
      if (tx_ack_o) begin
        in_full <= 1'b1;
        in_word <= tx_word_i;
      end else if (tx_bound) begin
        in_full <= 1'b0;
      end
    end
  end

  // Encoder: command beats data when any command bit is set
  always_comb begin
    enc_sym = 12'h000;
    cmd_nz  = 1'b0;
    case (width_i)
      SLC_W9: begin
        cmd_nz = |in_word.cmd[2:0];
        enc_sym = cmd_nz ? {slc_cmd9(in_word.cmd[2:0]), 1'b0}
                : {slc_enc5(in_word.data[8:4]), slc_enc4(in_word.data[3:0]), 1'b0};
      end
      SLC_W10: begin
        cmd_nz = |in_word.cmd[1:0];
        enc_sym = cmd_nz ? slc_cmd10(in_word.cmd[1:0])
                : {slc_enc5(in_word.data[8:4]),
                   slc_enc5({in_word.data[9], in_word.data[3:0]})};
      end
      default: begin
        cmd_nz = |in_word.cmd;
        enc_sym = cmd_nz ? {slc_cmd8(in_word.cmd), 2'b00}
                : {slc_enc4(in_word.data[7:4]), slc_enc4(in_word.data[3:0]), 2'b00};
      end
    endcase
  end

  // Shifter: reload at each byte window with data or Sync, MSB first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_cnt   <= '0;
      // This mode's Sync: a foreign pattern after reset could frame the far end early
      tx_shift <= sync_sym;
    end else if (ce_i) begin
      if (tx_bound) begin
        tx_cnt   <= '0;
        // A word strobed during this byte is still pending here
        tx_shift <= in_full ? enc_sym : sync_sym;
      end else begin
        tx_cnt   <= tx_cnt + SLC_CNT_W'(1);
        tx_shift <= {tx_shift[10:0], 1'b0};
      end
    end
  end

  // Line coder on the shifter's top bit
  slc_nrzi u_nrzi (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .bit_i  (tx_shift[11]),
    .line_o (serial_line_out_o)
  );

  // ---------------- Receiver ----------------
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_s3;
  logic       rx_prev;
  logic       rx_bit;
  logic [11:0] rx_hist;
  logic [11:0] rx_win;
  logic [SLC_CNT_W-1:0] rx_cnt;
  logic       rx_sync_hit;
  logic [SLC_CNT_W-1:0] half_len;

  // Three-stage synchroniser plus one delay flop for the NRZI decode.
  // At one bit per clock the line may toggle every cycle, so an agreement
  // filter would hide every run of ones; each sample counts as it comes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_s1   <= SLC_LINE_RST;
      rx_s2   <= SLC_LINE_RST;
      rx_s3   <= SLC_LINE_RST;
      rx_prev <= SLC_LINE_RST;
    end else if (ce_i) begin
      rx_s1   <= serial_line_in_i;
      rx_s2   <= rx_s1;
      rx_s3   <= rx_s2;
      rx_prev <= rx_s3;
    end
  end

  // NRZI decode: a change of line level is a one
  assign rx_bit = rx_s3 ^ rx_prev;

  // History, left shift, newest bit at LSB
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_hist <= SLC_WORD_RST;
    end else if (ce_i) begin
      rx_hist <= {rx_hist[10:0], rx_bit};
    end
  end

  // Newest byte_len bits, left aligned like the transmit symbol
  always_comb begin
    case (width_i)
      SLC_W9:  rx_win = {rx_hist[10:0], 1'b0};
      SLC_W10: rx_win = rx_hist;
      default: rx_win = {rx_hist[9:0], 2'b00};
    endcase
  end
  assign rx_sync_hit = (rx_win == sync_sym);
  // Upper symbol is five bits in eight-bit mode, six in the wider modes
  assign half_len    = (width_i == SLC_W8) ? SLC_CNT_W'(5) : SLC_CNT_W'(6);

  // Byte framing: Sync anywhere realigns the byte counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_cnt      <= '0;
      rx_framed_o <= 1'b0;
    end else if (ce_i) begin
      if (rx_sync_hit) begin
        rx_cnt      <= '0;
        rx_framed_o <= 1'b1;
      end else if (rx_cnt == byte_len - SLC_CNT_W'(1)) begin
        rx_cnt <= '0;
      end else begin
        rx_cnt <= rx_cnt + SLC_CNT_W'(1);
      end
    end
  end

  // Reverse lookup of a received symbol
  // Plain search over the code tables: easy to audit, costly only in simulation
  logic       dec_ok;
  logic       dec_cmd;
  slc_word_t  dec_word;
  logic       byte_end;
  always_comb begin
    dec_ok   = 1'b0;
    dec_cmd  = 1'b0;
    dec_word = '0;
    for (int v = 0; v < 1024; v++) begin
      if (width_i == SLC_W8 && v < 256 &&
          {slc_enc4(4'(v >> 4)), slc_enc4(4'(v)), 2'b00} == rx_win) begin
        dec_ok = 1'b1;
        dec_word.data = 10'(v);
      end
      if (width_i == SLC_W9 && v < 512 &&
          {slc_enc5(5'(v >> 4)), slc_enc4(4'(v)), 1'b0} == rx_win) begin
        dec_ok = 1'b1;
        dec_word.data = 10'(v);
      end
      if (width_i == SLC_W10 &&
          {slc_enc5(5'(v >> 4)), slc_enc5({1'(v >> 9), 4'(v)})} == rx_win) begin
        dec_ok = 1'b1;
        dec_word.data = 10'(v);
      end
    end
    for (int c = 1; c < 16; c++) begin
      if ((width_i == SLC_W8 && {slc_cmd8(4'(c)), 2'b00} == rx_win) ||
          (width_i == SLC_W9 && c < 8 && {slc_cmd9(3'(c)), 1'b0} == rx_win) ||
          (width_i == SLC_W10 && c < 4 && slc_cmd10(2'(c)) == rx_win)) begin
        dec_ok   = 1'b1;
        dec_cmd  = 1'b1;
        dec_word = '0;
        dec_word.cmd = 4'(c);
      end
    end
  end

  // Last bit of a framed byte arrives this cycle
  assign byte_end = rx_framed_o & (rx_cnt == byte_len - SLC_CNT_W'(1)) & ~rx_sync_hit;

  // Output latch and strobes; Sync leaves the word alone
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_word_o        <= '0;
      rx_data_strobe_o <= 1'b0;
      rx_cmd_strobe_o  <= 1'b0;
      rx_violation_o   <= 1'b0;
    end else if (ce_i) begin
      rx_data_strobe_o <= 1'b0;
      rx_cmd_strobe_o  <= 1'b0;
      rx_violation_o   <= 1'b0;
      if (byte_end) begin
        rx_word_o        <= dec_word;
        rx_data_strobe_o <= ~dec_cmd;
        rx_cmd_strobe_o  <= dec_cmd;
        rx_violation_o   <= ~dec_ok;
      end
    end
  end

  // Claim flag: first half decided at the half-byte point
  logic first_half_at;
  logic first_half_sync;
  logic cascade_prev;
  assign first_half_at   = (rx_cnt == half_len - SLC_CNT_W'(1));
  // Only the upper half's own bits; the bit before it belongs to the last byte
  assign first_half_sync = (width_i == SLC_W8) ? (rx_hist[4:0] == sync_sym[11:7])
                                               : (rx_hist[5:0] == sync_sym[11:6]);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      byte_claimed_flag_o <= 1'b0;
      cascade_prev        <= 1'b0;
    end else if (ce_i) begin
      cascade_prev <= cascade_enable_in_i;
      if (cascade_prev & ~cascade_enable_in_i) begin
        byte_claimed_flag_o <= 1'b0;
      end else if (first_half_at & rx_framed_o) begin
        if (first_half_sync) begin
          byte_claimed_flag_o <= 1'b0;
        end else if (cascade_enable_in_i) begin
          byte_claimed_flag_o <= 1'b1;
        end
      end
    end
  end

endmodule : slc_core
`default_nettype wire

// [rtl/slc_pkg.sv]
// Package: shared constants, types and code tables for the serial link coder
package slc_pkg;

  // Width modes: 8 data + 4 cmd, 9 + 3, 10 + 2
  typedef enum logic [1:0] {
    SLC_W8,
    SLC_W9,
    SLC_W10
  } slc_width_t;

  localparam int SLC_BUS_W    = 12;   // Parallel lines per side
  localparam int SLC_SYM_W    = 12;   // Widest encoded byte
  localparam int SLC_LEN_W8   = 10;   // Code bits per byte, 8-bit mode
  localparam int SLC_LEN_W9   = 11;
  localparam int SLC_LEN_W10  = 12;
  localparam int SLC_CNT_W    = 4;

  // Sync symbols, left aligned in 12 bits (unused low bits zero)
  localparam logic [11:0] SLC_SYNC_W8  = 12'hC44;  // 11000 10001 + 00
  localparam logic [11:0] SLC_SYNC_W9  = 12'h622;  // 011000 10001 + 0
  localparam logic [11:0] SLC_SYNC_W10 = 12'h623;  // 011000 100011

  // Reset values
  localparam logic        SLC_LINE_RST  = 1'b0;
  localparam logic [11:0] SLC_WORD_RST  = 12'h000;

  // Parallel word with its command/data split
  typedef struct packed {
    logic [9:0] data;
    logic [3:0] cmd;
  } slc_word_t;

  // 4B/5B data code
  function automatic logic [4:0] slc_enc4(input logic [3:0] n);
    logic [4:0] r;
    r = 5'h00;
    case (n)
      4'h0: r = 5'h1E;  4'h1: r = 5'h09;  4'h2: r = 5'h14;  4'h3: r = 5'h15;
      4'h4: r = 5'h0A;  4'h5: r = 5'h0B;  4'h6: r = 5'h0E;  4'h7: r = 5'h0F;
      4'h8: r = 5'h12;  4'h9: r = 5'h13;  4'hA: r = 5'h16;  4'hB: r = 5'h17;
      4'hC: r = 5'h1A;  4'hD: r = 5'h1B;  4'hE: r = 5'h1C;  default: r = 5'h1D;
    endcase
    return r;
  endfunction : slc_enc4

  // 5B/6B data code: 4B/5B pattern with the top input bit inserted third (1x-> xx1xxx, 0x-> xx0xxx), except 09, 0A and 12
  function automatic logic [5:0] slc_enc5(input logic [4:0] n);
    logic [5:0] r;
    r = 6'h00;
    case (n)
      5'h00: r = 6'h36;  5'h01: r = 6'h11;  5'h02: r = 6'h24;  5'h03: r = 6'h25;
      5'h04: r = 6'h12;  5'h05: r = 6'h13;  5'h06: r = 6'h16;  5'h07: r = 6'h17;
      5'h08: r = 6'h22;  5'h09: r = 6'h31;  5'h0A: r = 6'h37;  5'h0B: r = 6'h27;
      5'h0C: r = 6'h32;  5'h0D: r = 6'h33;  5'h0E: r = 6'h34;  5'h0F: r = 6'h35;
      5'h10: r = 6'h3E;  5'h11: r = 6'h19;  5'h12: r = 6'h29;  5'h13: r = 6'h2D;
      5'h14: r = 6'h1A;  5'h15: r = 6'h1B;  5'h16: r = 6'h1E;  5'h17: r = 6'h1F;
      5'h18: r = 6'h2A;  5'h19: r = 6'h2B;  5'h1A: r = 6'h2E;  5'h1B: r = 6'h2F;
      5'h1C: r = 6'h3A;  5'h1D: r = 6'h3B;  5'h1E: r = 6'h3C;  default: r = 6'h3D;
    endcase
    return r;
  endfunction : slc_enc5

  // 8-bit command symbols, 10 bits; index 0 unused
  function automatic logic [9:0] slc_cmd8(input logic [3:0] c);
    logic [9:0] r;
    r = 10'h000;
    case (c)
      4'h1: r = 10'h3FF;  4'h2: r = 10'h1AD;  4'h3: r = 10'h1B9;  4'h4: r = 10'h3E4;
      4'h5: r = 10'h1A7;  4'h6: r = 10'h327;  4'h7: r = 10'h339;  4'h8: r = 10'h084;
      4'h9: r = 10'h09F;  4'hA: r = 10'h080;  4'hB: r = 10'h0E7;  4'hC: r = 10'h0F9;
      4'hD: r = 10'h004;  4'hE: r = 10'h01F;  4'hF: r = 10'h000;  default: r = 10'h000;
    endcase
    return r;
  endfunction : slc_cmd8

  // 9-bit command symbols, 11 bits
  function automatic logic [10:0] slc_cmd9(input logic [2:0] c);
    logic [10:0] r;
    r = 11'h000;
    case (c)
      3'h1: r = 11'h7FF;  3'h2: r = 11'h3AD;  3'h3: r = 11'h3B9;  3'h4: r = 11'h7E4;
      3'h5: r = 11'h3A7;  3'h6: r = 11'h727;  3'h7: r = 11'h739;  default: r = 11'h000;
    endcase
    return r;
  endfunction : slc_cmd9

  // 10-bit command symbols, 12 bits
  function automatic logic [11:0] slc_cmd10(input logic [1:0] c);
    logic [11:0] r;
    r = 12'h000;
    case (c)
      2'h1: r = 12'hFFF;  2'h2: r = 12'h75D;  2'h3: r = 12'h779;  default: r = 12'h000;
    endcase
    return r;
  endfunction : slc_cmd10

endpackage : slc_pkg

// [rtl/slc_nrzi.sv]
// NRZI line stage: a one toggles the line, a zero holds it
`timescale 1ns/1ps
`default_nettype none
module slc_nrzi
  import slc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic bit_i,
  output logic      line_o
);
  // Toggle on one, hold on zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_o <= SLC_LINE_RST;
    end else if (ce_i) begin
      line_o <= line_o ^ bit_i;
    end
  end
endmodule : slc_nrzi
`default_nettype wire

// [tb/slc_core_asserts.sv]
// Port-level checks for the serial link coder
`timescale 1ns/1ps
`default_nettype none
module slc_core_asserts
  import slc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       ce_i,
  input wire slc_width_t width_i,
  input wire slc_word_t  tx_word_i,
  input wire logic       word_strobe_in_i,
  input wire logic       tx_ack_o,
  input wire logic       serial_line_out_o,
  input wire logic       serial_line_in_i,
  input wire logic       cascade_enable_in_i,
  input wire slc_word_t  rx_word_o,
  input wire logic       rx_data_strobe_o,
  input wire logic       rx_cmd_strobe_o,
  input wire logic       rx_violation_o,
  input wire logic       byte_claimed_flag_o,
  input wire logic       rx_framed_o
);
  logic rx_any;

  // Either receive strobe
  assign rx_any = rx_data_strobe_o | rx_cmd_strobe_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Handshake and receive-side shape
  ack_has_cause_a: assert property (tx_ack_o |-> word_strobe_in_i && ce_i)
    else $error("ack without strobe");
  rx_kind_excl_a: assert property (!(rx_data_strobe_o && rx_cmd_strobe_o))
    else $error("data and command strobe together");
  rx_pulse_gap_a: assert property (rx_any |=> (!rx_any) [*8])
    else $error("receive strobes too close");
  word_hold_a: assert property (!$stable(rx_word_o) |-> rx_any)
    else $error("output word changed without strobe");
  cmd_shape_a: assert property (rx_cmd_strobe_o && !rx_violation_o |-> rx_word_o.data == 10'h000 && rx_word_o.cmd != 4'h0)
    else $error("bad command word shape");
  data_shape_a: assert property (rx_data_strobe_o |-> rx_word_o.cmd == 4'h0)
    else $error("data word carries command bits");
  // Claim flag and framing
  claim_drop_a: assert property ($fell(cascade_enable_in_i) && ce_i |=> !byte_claimed_flag_o)
    else $error("claim flag kept after enable fell");
  claim_cause_a: assert property ($rose(byte_claimed_flag_o) |-> $past(cascade_enable_in_i))
    else $error("claim flag rose without enable");
  framed_keep_a: assert property (!$fell(rx_framed_o))
    else $error("framing lost without reset");

  cover property (rx_cmd_strobe_o);
  cover property (rx_data_strobe_o);
  cover property ($fell(byte_claimed_flag_o));
endmodule : slc_core_asserts

bind slc_core slc_core_asserts u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .width_i(width_i), .tx_word_i(tx_word_i),
  .word_strobe_in_i(word_strobe_in_i), .tx_ack_o(tx_ack_o), .serial_line_out_o(serial_line_out_o),
  .serial_line_in_i(serial_line_in_i), .cascade_enable_in_i(cascade_enable_in_i), .rx_word_o(rx_word_o),
  .rx_data_strobe_o(rx_data_strobe_o), .rx_cmd_strobe_o(rx_cmd_strobe_o), .rx_violation_o(rx_violation_o),
  .byte_claimed_flag_o(byte_claimed_flag_o), .rx_framed_o(rx_framed_o)
);
`default_nettype wire

// [tb/slc_host.sv]
// Host model: strobes words into the transmitter
`timescale 1ns/1ps
`default_nettype none
module slc_host
  import slc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic tx_ack_i,
  output var logic  word_strobe_o,
  output slc_word_t tx_word_o
);
  initial begin
    word_strobe_o = 1'b0;
    tx_word_o = '0;
  end

  // Word and strobe held until ack is high at a rising edge
  task automatic send(input slc_word_t w, output bit ok);
    int n;
    @(posedge clk_i);
    tx_word_o <= w;
    word_strobe_o <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tx_ack_i !== 1'b1 && n < 60);
    ok = (tx_ack_i === 1'b1);
    @(posedge clk_i);
    word_strobe_o <= 1'b0;
  endtask : send
endmodule : slc_host
`default_nettype wire

// [tb/slc_core_bench.sv]
// Loopback bench: host model sends, receiver output compared
`timescale 1ns/1ps
`default_nettype none
module slc_core_bench
  import slc_pkg::*;
();
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       ce_i = 1'b1;
  slc_width_t width_i = SLC_W8;
  slc_word_t  tx_word_i;
  logic       word_strobe_in_i;
  logic       tx_ack_o;
  logic       line;
  logic       cascade_enable_in_i = 1'b0;
  slc_word_t  rx_word_o;
  logic       rx_data_strobe_o;
  logic       rx_cmd_strobe_o;
  logic       rx_violation_o;
  logic       byte_claimed_flag_o;
  logic       rx_framed_o;
  logic [11:0] nrz = 12'h000;
  logic       prev = 1'b0;
  int         errors = 0;
  int         checks = 0;
  int         mode = 0;
  slc_word_t  mon_exp;
  slc_word_t  expq[$];

  always #50 clk_i = ~clk_i;

  // Serial line looped back to the receiver
  slc_core dut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .width_i(width_i), .tx_word_i(tx_word_i),
    .word_strobe_in_i(word_strobe_in_i), .tx_ack_o(tx_ack_o), .serial_line_out_o(line),
    .serial_line_in_i(line), .cascade_enable_in_i(cascade_enable_in_i), .rx_word_o(rx_word_o),
    .rx_data_strobe_o(rx_data_strobe_o), .rx_cmd_strobe_o(rx_cmd_strobe_o),
    .rx_violation_o(rx_violation_o), .byte_claimed_flag_o(byte_claimed_flag_o), .rx_framed_o(rx_framed_o)
  );

  slc_host host (.clk_i(clk_i), .tx_ack_i(tx_ack_o), .word_strobe_o(word_strobe_in_i), .tx_word_o(tx_word_i));

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Commands win over data; unused bits of the mode drop out
  function automatic slc_word_t exp_of(input int m, input slc_word_t x);
    slc_word_t r;
    logic [3:0] cm;
    cm = 4'hF >> m;
    r = '0;
    if ((x.cmd & cm) != 4'h0) r.cmd = x.cmd & cm;
    else r.data = x.data & (10'h3FF >> (2 - m));
    return r;
  endfunction : exp_of

  task automatic put(input slc_word_t x);
    bit ok;
    expq.push_back(exp_of(mode, x));
    host.send(x, ok);
    if (!ok) begin
      errors++;
      close_out();
    end
  endtask : put

  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 400) begin
      errors++;
      close_out();
    end
  endtask : drain

  // Outputs settled at the falling edge; NRZI undone into nrz
  always @(negedge clk_i) begin
    nrz <= {nrz[10:0], line ^ prev};
    prev <= line;
    if (!srst_i && (rx_data_strobe_o === 1'b1 || rx_cmd_strobe_o === 1'b1)) begin
      if (expq.size() == 0) begin
        check(14'h0001, 14'h0000);
      end else begin
        mon_exp = expq.pop_front();
        check(rx_word_o, mon_exp);
        check(14'(rx_cmd_strobe_o), 14'(mon_exp.cmd != 4'h0));
        check(14'(rx_violation_o), 14'h0000);
      end
    end
  end

  initial begin
    slc_word_t x;
    logic [11:0] s;
    logic held;
    int n;
    void'($urandom(32'h3159866f));
    for (mode = 0; mode < 3; mode++) begin
      @(posedge clk_i);
      srst_i <= 1'b1;
      width_i <= slc_width_t'(mode);
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      n = 0;
      while (rx_framed_o !== 1'b1 && n < 100) begin
        @(negedge clk_i);
        n++;
      end
      check(14'(rx_framed_o), 14'h0001);
      if (rx_framed_o !== 1'b1) close_out();
      // Idle line must show the mode's sync, first bit first
      s = (mode == 0) ? SLC_SYNC_W8 >> 2 : (mode == 1) ? SLC_SYNC_W9 >> 1 : SLC_SYNC_W10;
      n = 0;
      while (((nrz ^ s) & (12'hFFF >> (2 - mode))) != 12'h000 && n < 40) begin
        @(negedge clk_i);
        n++;
      end
      check(14'(n < 40), 14'h0001);
      if (n >= 40) close_out();
      // Every command code of the mode, random data beside it
      for (int c = 1; c <= (15 >> mode); c++) begin
        x.data = 10'($urandom);
        x.cmd = 4'(c);
        put(x);
      end
      put(slc_word_t'(14'h0000));
      put(slc_word_t'({10'h3FF, 4'h0}));
      // Random words, often back to back so the latch is busy
      repeat (16) begin
        x = slc_word_t'(14'($urandom));
        if ($urandom % 4 != 0) x.cmd = 4'h0;
        repeat (($urandom % 3 == 0) ? 7 : 0) @(posedge clk_i);
        put(x);
      end
      drain();
      // Claim flag: set, cleared by sync, cleared by enable fall
      @(posedge clk_i);
      cascade_enable_in_i <= 1'b1;
      put(x);
      drain();
      check(14'(byte_claimed_flag_o), 14'h0001);
      repeat (30) @(negedge clk_i);
      check(14'(byte_claimed_flag_o), 14'h0000);
      check(rx_word_o, mon_exp);
      // Clock enable low: line and handshake freeze while the host waits
      @(posedge clk_i);
      ce_i <= 1'b0;
      fork
        put(x);
        begin
          @(negedge clk_i);
          held = line;
          repeat (6) @(negedge clk_i);
          check(14'(line), 14'(held));
          check(14'(word_strobe_in_i), 14'h0001);
          check(14'(tx_ack_o), 14'h0000);
          @(posedge clk_i);
          ce_i <= 1'b1;
        end
      join
      drain();
      @(posedge clk_i);
      cascade_enable_in_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      check(14'(byte_claimed_flag_o), 14'h0000);
    end
    close_out();
  end
endmodule : slc_core_bench
`default_nettype wire
